// [src/nibio_ports.sv]
// four nibble ports: input port, output port and two quasi-bidirectional ports
`timescale 1ns/100ps
module nibio_ports
  import nibio_pkg::*;
#(
  parameter nibio_fmt_type OUT_FMT   = NIBIO_FMT_PP,
  parameter nibio_fmt_type BIDA_FMT  = NIBIO_FMT_OD_PU,
  parameter nibio_fmt_type BIDB_FMT  = NIBIO_FMT_OD,
  parameter bit            EXT_CLOCK = 1'b1
) (
  input  wire logic                   CLK_SYS,
  input  wire logic                   RST_N,
  input  wire logic                   PORT_READ_INSTR,
  input  wire logic                   PORT_WRITE_INSTR,
  input  wire logic                   PORT_BIT_SET_INSTR,
  input  wire logic                   PORT_BIT_CLEAR_INSTR,
  input  wire logic [3:0]             LOW_REG,
  input  wire logic [1:0]             BIT_SEL,
  input  wire logic [3:0]             ACC_IN,
  input  wire logic [3:0]             COUNT_MODE,
  input  wire logic [3:0]             SHIFT_MODE,
  input  wire logic [3:0]             IN_PORT_PINS,
  input  wire logic [3:0]             BIDA_PINS_I,
  input  wire logic [3:0]             BIDB_PINS_I,
  output logic      [3:0]             ACC_OUT,
  output logic                        ACC_OUT_VALID,
  output logic                        INPUT_PIN_ZERO_COUNT,
  output logic                        TESTABLE_EVENT_INPUT,
  output logic                        SERIAL_PINS_ACTIVE,
  output logic      [3:0]             OUT_PORT_O,
  output logic      [3:0]             OUT_PORT_OE,
  output logic      [3:0]             BIDA_PINS_O,
  output logic      [3:0]             BIDA_PINS_OE,
  output logic      [3:0]             BIDA_PULL_UP,
  output logic      [3:0]             BIDB_PINS_O,
  output logic      [3:0]             BIDB_PINS_OE,
  output logic      [3:0]             BIDB_PULL_UP
);
  import nibio_pkg::*;

  // ****************************************************************
  // decode
  // ****************************************************************
  // one-hot mask of a bit position
  function automatic logic [3:0] bit_mask(input logic [1:0] pos);
    bit_mask = 4'h1 << pos;
  endfunction

  // new latch value from write, set or clear
  function automatic logic [3:0] latch_next(input logic [3:0] cur, input logic [3:0] acc,
                                            input logic wr, input logic set,
                                            input logic clr, input logic [1:0] pos);
    logic [3:0] r;
    r = cur;
    if (wr) begin
      r = acc;
    end else if (set) begin
      r = cur | bit_mask(pos);
    end else if (clr) begin
      r = cur & ~bit_mask(pos);
    end
    latch_next = r;
  endfunction

  wire logic sel_in    = (LOW_REG == NIBIO_SEL_IN);
  wire logic sel_out   = (LOW_REG == NIBIO_SEL_OUT);
  wire logic sel_bida  = (LOW_REG == NIBIO_SEL_BIDIR_A);
  wire logic sel_bidb  = (LOW_REG == NIBIO_SEL_BIDIR_B);
  wire logic any_bit   = PORT_BIT_SET_INSTR | PORT_BIT_CLEAR_INSTR;
  wire logic out_hit   = sel_out & (PORT_WRITE_INSTR | any_bit);
  wire logic bida_hit  = sel_bida & (PORT_WRITE_INSTR | any_bit);
  wire logic bidb_hit  = sel_bidb & (PORT_WRITE_INSTR | any_bit);
  // top output bit only exists with the external clock option
  wire logic [3:0] out_avail = EXT_CLOCK ? 4'hF : 4'h7;
  // pull-up resistors are present from reset on, before any write
  localparam logic [3:0] bida_pu_rst = (BIDA_FMT == NIBIO_FMT_OD_PU) ? 4'hF : 4'h0;
  localparam logic [3:0] bidb_pu_rst = (BIDB_FMT == NIBIO_FMT_OD_PU) ? 4'hF : 4'h0;

  // ****************************************************************
  // latches
  // ****************************************************************
  logic [3:0] out_latch_q, bida_latch_q, bidb_latch_q;
  logic       out_drv_q, bida_drv_q, bidb_drv_q;
  logic [3:0] out_latch_d, bida_latch_d, bidb_latch_d;

  assign out_latch_d  = latch_next(out_latch_q, ACC_IN, PORT_WRITE_INSTR,
                                   PORT_BIT_SET_INSTR, PORT_BIT_CLEAR_INSTR, BIT_SEL);
  assign bida_latch_d = latch_next(bida_latch_q, ACC_IN, PORT_WRITE_INSTR,
                                   PORT_BIT_SET_INSTR, PORT_BIT_CLEAR_INSTR, BIT_SEL);
  assign bidb_latch_d = latch_next(bidb_latch_q, ACC_IN, PORT_WRITE_INSTR,
                                   PORT_BIT_SET_INSTR, PORT_BIT_CLEAR_INSTR, BIT_SEL);

  // output port latch; reset floats the pins
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      out_latch_q <= NIBIO_LATCH_RST;
      out_drv_q   <= 1'b0;
    end else if (out_hit) begin
      out_latch_q <= out_latch_d;
      out_drv_q   <= 1'b1;
    end
  end

  // bidirectional latches hold until next write, bit set, bit clear or reset; reads leave them
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      bida_latch_q <= NIBIO_LATCH_RST;
      bidb_latch_q <= NIBIO_LATCH_RST;
      bida_drv_q   <= 1'b0;
      bidb_drv_q   <= 1'b0;
    end else begin
      if (bida_hit) begin
        bida_latch_q <= bida_latch_d;
        bida_drv_q   <= 1'b1;
      end
      if (bidb_hit) begin
        bidb_latch_q <= bidb_latch_d;
        bidb_drv_q   <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // pin drivers
  // ****************************************************************
  nibio_pin_if out_if ();
  nibio_pin_if bida_if ();
  nibio_pin_if bidb_if ();
  assign out_if.latch   = out_latch_q;
  assign out_if.driven  = out_drv_q;
  assign bida_if.latch  = bida_latch_q;
  assign bida_if.driven = bida_drv_q;
  assign bidb_if.latch  = bidb_latch_q;
  assign bidb_if.driven = bidb_drv_q;

  nibio_pad_drv #(.FMT(OUT_FMT))  u_out  (.p(out_if.drv));
  nibio_pad_drv #(.FMT(BIDA_FMT)) u_bida (.p(bida_if.drv));
  nibio_pad_drv #(.FMT(BIDB_FMT)) u_bidb (.p(bidb_if.drv));

  // ****************************************************************
  // reads and alternate functions
  // ****************************************************************
  // input and bidirectional pins are read directly, so open-drain high latches see the line
  wire logic [3:0] rd_mux = sel_in   ? IN_PORT_PINS :
                            sel_bida ? BIDA_PINS_I  :
                            sel_bidb ? BIDB_PINS_I  :
                            sel_out  ? (out_latch_q & out_avail) : 4'h0;
  wire logic cnt_ext = ({COUNT_MODE[NIBIO_CNT_SEL_HI_BIT], COUNT_MODE[NIBIO_CNT_SEL_LO_BIT]}
                        == NIBIO_CNT_EXT_CODE);
  wire logic ser_on  = ({SHIFT_MODE[NIBIO_SER_SEL_HI_BIT], SHIFT_MODE[NIBIO_SER_SEL_LO_BIT]}
                        != NIBIO_SER_OFF_CODE);

  // registered outputs
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      ACC_OUT              <= 4'h0;
      ACC_OUT_VALID        <= 1'b0;
      INPUT_PIN_ZERO_COUNT <= 1'b0;
      TESTABLE_EVENT_INPUT <= 1'b0;
      SERIAL_PINS_ACTIVE   <= 1'b0;
      OUT_PORT_O           <= 4'h0;
      OUT_PORT_OE          <= 4'h0;
      BIDA_PINS_O          <= 4'h0;
      BIDA_PINS_OE         <= 4'h0;
      BIDA_PULL_UP         <= bida_pu_rst;
      BIDB_PINS_O          <= 4'h0;
      BIDB_PINS_OE         <= 4'h0;
      BIDB_PULL_UP         <= bidb_pu_rst;
    end else begin
      ACC_OUT              <= PORT_READ_INSTR ? rd_mux : ACC_OUT;
      ACC_OUT_VALID        <= PORT_READ_INSTR;
      INPUT_PIN_ZERO_COUNT <= cnt_ext & IN_PORT_PINS[0];
      TESTABLE_EVENT_INPUT <= SHIFT_MODE[NIBIO_EVT_EN_BIT] & IN_PORT_PINS[0];
      SERIAL_PINS_ACTIVE   <= ser_on;
      OUT_PORT_O           <= out_if.pad_o & out_avail;
      OUT_PORT_OE          <= out_if.pad_oe & out_avail;
      BIDA_PINS_O          <= bida_if.pad_o;
      BIDA_PINS_OE         <= bida_if.pad_oe;
      BIDA_PULL_UP         <= bida_if.pull_up;
      BIDB_PINS_O          <= bidb_if.pad_o;
      BIDB_PINS_OE         <= bidb_if.pad_oe;
      BIDB_PULL_UP         <= bidb_if.pull_up;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  sequence wr_out_s;
    PORT_WRITE_INSTR && sel_out;
  endsequence
  // write to bidirectional port a
  sequence wr_bida_s;
    PORT_WRITE_INSTR && sel_bida;
  endsequence
  // write to bidirectional port b
  sequence wr_bidb_s;
    PORT_WRITE_INSTR && sel_bidb;
  endsequence
  // lone bit set on the output port
  sequence set_out_s;
    PORT_BIT_SET_INSTR && !PORT_WRITE_INSTR && sel_out;
  endsequence
  // lone bit clear on bidirectional port b
  sequence clr_bidb_s;
    PORT_BIT_CLEAR_INSTR && !PORT_WRITE_INSTR && !PORT_BIT_SET_INSTR && sel_bidb;
  endsequence
  // read of a selector that maps to no port
  sequence rd_unmapped_s;
    PORT_READ_INSTR && !sel_in && !sel_out && !sel_bida && !sel_bidb;
  endsequence
  // store aimed at the input-only port
  sequence in_store_s;
    (PORT_WRITE_INSTR || any_bit) && sel_in;
  endsequence
  // push-pull port a after its first write
  sequence pp_driven_s;
    bida_drv_q && (BIDA_FMT == NIBIO_FMT_PP);
  endsequence

  read_input_a: assert property (PORT_READ_INSTR && sel_in |=> ACC_OUT == $past(IN_PORT_PINS))
    else $error("input port read wrong");
  count_src_a: assert property (cnt_ext && IN_PORT_PINS[0] |=> INPUT_PIN_ZERO_COUNT)
    else $error("count source not routed");
  event_gate_a: assert property (!SHIFT_MODE[NIBIO_EVT_EN_BIT] |=> !TESTABLE_EVENT_INPUT)
    else $error("event input without enable");
  out_write_a: assert property (wr_out_s |=> ##1 OUT_PORT_OE != 4'h0 || OUT_FMT != NIBIO_FMT_PP)
    else $error("output port not driven");
  bit_only_a: assert property (PORT_BIT_SET_INSTR && !PORT_WRITE_INSTR && sel_bida
                               |=> bida_latch_q == ($past(bida_latch_q) | bit_mask($past(BIT_SEL))))
    else $error("bit set touched other bits");
  top_bit_a: assert property (!EXT_CLOCK |-> !OUT_PORT_OE[NIBIO_TOP_BIT])
    else $error("top bit driven with rc oscillator");
  read_keeps_a: assert property (PORT_READ_INSTR && !bida_hit |=> $stable(bida_latch_q))
    else $error("read changed latch");
  pp_stays_a: assert property (pp_driven_s |=> ##1 BIDA_PINS_OE == 4'hF)
    else $error("port returned to input");

  // read data strobe is a single cycle per read
  read_valid_a: assert property (PORT_READ_INSTR |=> ACC_OUT_VALID)
    else $error("read strobe missing");
  valid_pulse_a: assert property (!PORT_READ_INSTR |=> !ACC_OUT_VALID)
    else $error("read strobe without read");
  // output port write lands in the latch, then on the pins
  out_latch_a: assert property (wr_out_s |=> out_latch_q == $past(ACC_IN))
    else $error("output latch not written");
  out_pins_a: assert property (wr_out_s |=> ##1 OUT_FMT != NIBIO_FMT_PP
      || OUT_PORT_O == ($past(ACC_IN, 2) & out_avail))
    else $error("output pins wrong after write");
  // bit set on the output port touches only the addressed bit
  out_set_a: assert property (set_out_s |=>
      out_latch_q == ($past(out_latch_q) | bit_mask($past(BIT_SEL))))
    else $error("output bit set wrong");
  // writes to the bidirectional ports latch and start driving
  bida_write_a: assert property (wr_bida_s |=>
      bida_drv_q && bida_latch_q == $past(ACC_IN))
    else $error("port a latch not written");
  bidb_write_a: assert property (wr_bidb_s |=>
      bidb_drv_q && bidb_latch_q == $past(ACC_IN))
    else $error("port b latch not written");
  // bit clear on a bidirectional port touches only the addressed bit
  bidb_clear_a: assert property (clr_bidb_s |=>
      bidb_latch_q == ($past(bidb_latch_q) & ~bit_mask($past(BIT_SEL))))
    else $error("port b bit clear wrong");
  // open-drain pins latched high are released for reads
  od_release_a: assert property (BIDB_FMT != NIBIO_FMT_PP && bidb_drv_q |=>
      BIDB_PINS_OE == ~$past(bidb_latch_q))
    else $error("open-drain high pin still pulled low");
  // no pin is driven before the first write
  out_float_a: assert property (!out_drv_q |=> OUT_PORT_OE == 4'h0)
    else $error("output port driven before write");
  bid_float_a: assert property (!bida_drv_q && !bidb_drv_q |=>
      BIDA_PINS_OE == 4'h0 && BIDB_PINS_OE == 4'h0)
    else $error("bidirectional port driven before write");
  // serial role follows the select bits
  serial_on_a: assert property (ser_on |=> SERIAL_PINS_ACTIVE)
    else $error("serial role missing");
  serial_off_a: assert property (!ser_on |=> !SERIAL_PINS_ACTIVE)
    else $error("serial role without select");
  // event input passes the pin when enabled
  event_on_a: assert property (SHIFT_MODE[NIBIO_EVT_EN_BIT] && IN_PORT_PINS[0] |=>
      TESTABLE_EVENT_INPUT)
    else $error("event input not passed");
  // output port reads its latch, top bit only with the external clock
  out_read_a: assert property (PORT_READ_INSTR && sel_out |=>
      ACC_OUT == ($past(out_latch_q) & out_avail))
    else $error("output port read wrong");
  // unmapped reads give zero and the input port stores nothing
  unmapped_rd_a: assert property (rd_unmapped_s |=> ACC_OUT == 4'h0)
    else $error("unmapped read not zero");
  in_store_a: assert property (in_store_s |=>
      $stable(out_latch_q) && $stable(bida_latch_q) && $stable(bidb_latch_q))
    else $error("input port store changed a latch");
endmodule

// [inc/nibio_pkg.sv]
// package of constants and types for the nibble io ports block
package nibio_pkg;
  // port selector codes carried in the low general register
  localparam logic [3:0] NIBIO_SEL_IN      = 4'h0;
  localparam logic [3:0] NIBIO_SEL_OUT     = 4'h8;
  localparam logic [3:0] NIBIO_SEL_BIDIR_A = 4'hA;
  localparam logic [3:0] NIBIO_SEL_BIDIR_B = 4'hB;
  // bit positions inside mode bits
  localparam int NIBIO_CNT_SEL_HI_BIT  = 2;
  localparam int NIBIO_CNT_SEL_LO_BIT  = 1;
  localparam int NIBIO_EVT_EN_BIT      = 3;
  localparam int NIBIO_SER_SEL_HI_BIT  = 2;
  localparam int NIBIO_SER_SEL_LO_BIT  = 1;
  localparam logic [1:0] NIBIO_CNT_EXT_CODE = 2'h1;
  localparam logic [1:0] NIBIO_SER_OFF_CODE = 2'h0;
  // reset value of latches (content undefined, chosen all ones)
  localparam logic [3:0] NIBIO_LATCH_RST    = 4'hF;
  localparam int NIBIO_WIDTH               = 4;
  localparam int NIBIO_TOP_BIT             = 3;
  // build-time output formats
  typedef enum logic [1:0] {
    NIBIO_FMT_OD,
    NIBIO_FMT_OD_PU,
    NIBIO_FMT_PP
  } nibio_fmt_type;
endpackage

// [inc/nibio_if.sv]
// interface between the port core and one port's pin driver (output or bidirectional)
`timescale 1ns/100ps
interface nibio_pin_if;
  logic [3:0] latch;
  logic       driven;
  logic [3:0] pad_o;
  logic [3:0] pad_oe;
  logic [3:0] pull_up;
  modport core (output latch, output driven, input pad_o, input pad_oe, input pull_up);
  modport drv  (input latch, input driven, output pad_o, output pad_oe, output pull_up);
endinterface

// [src/nibio_pad_drv.sv]
// output structure of one 4-bit latched port
`timescale 1ns/100ps
module nibio_pad_drv
  import nibio_pkg::*;
#(
  parameter nibio_fmt_type FMT = NIBIO_FMT_OD
) (
  nibio_pin_if.drv p
);
  genvar i;
  // per-bit drive: push-pull drives both levels, open-drain pulls low only
  generate
    for (i = 0; i < NIBIO_WIDTH; i++) begin : g_bit
      assign p.pad_o[i]   = (FMT == NIBIO_FMT_PP) ? p.latch[i] : 1'b0;
      assign p.pad_oe[i]  = p.driven & ((FMT == NIBIO_FMT_PP) | ~p.latch[i]);
      assign p.pull_up[i] = (FMT == NIBIO_FMT_OD_PU);
    end
  endgenerate
endmodule

// [verification/nibio_pins_model.sv]
// external circuits on the two quasi-bidirectional ports
`timescale 1ns/100ps
module nibio_pins_model (
  input  wire logic       clk,
  input  wire logic [7:0] dut_o,
  input  wire logic [7:0] dut_oe,
  input  wire logic [7:0] pull_up,
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_oe,
  output logic      [7:0] pins
);
  logic [7:0] wander_q = 8'h5A;
  // a floating line wanders each cycle, never holds its last value
  always @(posedge clk) begin
    wander_q <= ~wander_q;
  end
  // low wins on a shared line, then pull-up, then wander
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (dut_oe[i] && ext_oe[i]) pins[i] = dut_o[i] & ext_val[i];
      else if (dut_oe[i]) pins[i] = dut_o[i];
      else if (ext_oe[i]) pins[i] = ext_val[i];
      else pins[i] = pull_up[i] ? 1'b1 : wander_q[i];
    end
  end
endmodule

// [verification/nibble_io_ports_tb_top.sv]
// self-checking bench of the nibble io ports block
`timescale 1ns/100ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module nibble_io_ports_tb_top;
  import nibio_pkg::*;
  logic       CLK_SYS = 0, RST_N = 0;
  logic [3:0] ins = 0, LOW_REG = 0, ACC_IN = 0, COUNT_MODE = 0, SHIFT_MODE = 0, IN_PORT_PINS = 0;
  logic [1:0] BIT_SEL = 0;
  logic [7:0] ev = 0, eoe = 0, pins;
  logic [3:0] acco, oo, ooe, ao, aoe, apu, bo, boe, bpu, x_ooe, x_aoe, x_bpu, x_ao, ex;
  logic       vld, cnt, evt, ser;
  logic [3:0] exp_q[$], lat[3];
  logic [3:0] sel_t[3] = '{NIBIO_SEL_OUT, NIBIO_SEL_BIDIR_A, NIBIO_SEL_BIDIR_B};
  int         error_cnt = 0, num_checks = 0, cyc = 0, k, s, b;
  always #2.5 CLK_SYS = ~CLK_SYS;
  // device with default formats, and a variant with the other formats
  nibio_ports i_dut (.CLK_SYS, .RST_N, .PORT_READ_INSTR(ins[0]), .PORT_WRITE_INSTR(ins[1]),
    .PORT_BIT_SET_INSTR(ins[2]), .PORT_BIT_CLEAR_INSTR(ins[3]), .LOW_REG, .BIT_SEL, .ACC_IN,
    .COUNT_MODE, .SHIFT_MODE, .IN_PORT_PINS, .BIDA_PINS_I(pins[3:0]), .BIDB_PINS_I(pins[7:4]),
    .ACC_OUT(acco), .ACC_OUT_VALID(vld), .INPUT_PIN_ZERO_COUNT(cnt), .TESTABLE_EVENT_INPUT(evt),
    .SERIAL_PINS_ACTIVE(ser), .OUT_PORT_O(oo), .OUT_PORT_OE(ooe), .BIDA_PINS_O(ao),
    .BIDA_PINS_OE(aoe), .BIDA_PULL_UP(apu), .BIDB_PINS_O(bo), .BIDB_PINS_OE(boe),
    .BIDB_PULL_UP(bpu));
  nibio_ports #(.OUT_FMT(NIBIO_FMT_OD), .BIDA_FMT(NIBIO_FMT_PP), .BIDB_FMT(NIBIO_FMT_OD_PU),
    .EXT_CLOCK(1'b0)) i_dut_alt (.CLK_SYS, .RST_N, .PORT_READ_INSTR(ins[0]),
    .PORT_WRITE_INSTR(ins[1]), .PORT_BIT_SET_INSTR(ins[2]), .PORT_BIT_CLEAR_INSTR(ins[3]),
    .LOW_REG, .BIT_SEL, .ACC_IN, .COUNT_MODE, .SHIFT_MODE, .IN_PORT_PINS,
    .BIDA_PINS_I(pins[3:0]), .BIDB_PINS_I(pins[7:4]), .ACC_OUT(), .ACC_OUT_VALID(),
    .INPUT_PIN_ZERO_COUNT(), .TESTABLE_EVENT_INPUT(), .SERIAL_PINS_ACTIVE(), .OUT_PORT_O(),
    .OUT_PORT_OE(x_ooe), .BIDA_PINS_O(x_ao), .BIDA_PINS_OE(x_aoe), .BIDA_PULL_UP(),
    .BIDB_PINS_O(), .BIDB_PINS_OE(), .BIDB_PULL_UP(x_bpu));
  nibio_pins_model i_pins (.clk(CLK_SYS), .dut_o({bo, ao}), .dut_oe({boe, aoe}),
    .pull_up({bpu, apu}), .ext_val(ev), .ext_oe(eoe), .pins(pins));
  // one instruction pulse, then settle time for pins and read data
  task automatic op(input int k, input logic [3:0] sel, a, input logic [1:0] bs);
    @(posedge CLK_SYS);
    #1 {LOW_REG, ACC_IN, BIT_SEL} = {sel, a, bs};
    ins = 4'(1 << k);
    @(posedge CLK_SYS);
    #1 ins = 4'h0;
    repeat (3) @(posedge CLK_SYS);
    #1;
  endtask
  task automatic rd(input logic [3:0] sel, input logic [3:0] e);
    exp_q.push_back(e);
    op(0, sel, 4'h0, 2'h0);
  endtask
  task automatic test_done;
    `CHK("pending", 0, exp_q.size())
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // read data watcher, oldest note first
  always @(negedge CLK_SYS) begin
    if (vld === 1'b1) begin
      ex = (exp_q.size() > 0) ? exp_q.pop_front() : 4'hx;
      `CHK("acc_out", ex, acco)
    end
  end
  // hang guard
  always @(posedge CLK_SYS) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      test_done();
    end
  end
  initial begin
    void'($urandom(32'he32c));
    repeat (8) @(posedge CLK_SYS);
    #1 RST_N = 1;
    rd(NIBIO_SEL_BIDIR_A, 4'hF);
    `CHK("oe_rst", 4'h0, ooe | aoe | boe)
    `CHK("pu_rst", 8'hF0, {apu, bpu})
    `CHK("alt_pu", 4'hF, x_bpu)
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      IN_PORT_PINS = 4'($urandom) | 4'h1;
      COUNT_MODE = {1'b0, 2'(i), 1'b0};
      SHIFT_MODE = {i[0], 2'(i), 1'b0};
      rd(NIBIO_SEL_IN, IN_PORT_PINS);
      `CHK("count", 1'(i == 1), cnt)
      `CHK("event", i[0], evt)
      `CHK("serial", 1'(i != 0), ser)
    end
    $display("test input port done");
    lat[0] = 4'($urandom);
    op(1, NIBIO_SEL_OUT, lat[0], 2'h0);
    `CHK("out_o", lat[0], oo)
    `CHK("out_oe", 4'hF, ooe)
    `CHK("alt_ooe", {1'b0, ~lat[0][2:0]}, x_ooe)
    lat[1] = 4'($urandom);
    op(1, NIBIO_SEL_BIDIR_A, lat[1], 2'h0);
    `CHK("a_oe", ~lat[1], aoe)
    `CHK("alt_aoe", 4'hF, x_aoe)
    `CHK("alt_ao", lat[1], x_ao)
    `CHK("od_o", 8'h00, {ao, bo})
    rd(NIBIO_SEL_BIDIR_A, lat[1]);
    ev = 8'($urandom);
    eoe = 8'hFF;
    lat[2] = 4'hF;
    op(1, NIBIO_SEL_BIDIR_B, lat[2], 2'h0);
    rd(NIBIO_SEL_BIDIR_A, lat[1] & ev[3:0]);
    rd(NIBIO_SEL_BIDIR_B, ev[7:4]);
    `CHK("a_oe_hold", ~lat[1], aoe)
    `CHK("alt_aoe_hold", 4'hF, x_aoe)
    $display("test port writes done");
    for (int i = 0; i < 9; i++) begin
      k = $urandom_range(3, 2);
      b = $urandom_range(3, 0);
      s = i % 3;
      op(k, sel_t[s], 4'h0, 2'(b));
      lat[s][b] = (k == 2);
      `CHK("out_bits", lat[0], oo)
    end
    rd(sel_t[0], lat[0]);
    rd(sel_t[1], lat[1] & ev[3:0]);
    rd(sel_t[2], lat[2] & ev[7:4]);
    $display("test bit ops done");
    op(1, NIBIO_SEL_IN, ~lat[0], 2'h0);
    op(1, 4'h5, ~lat[0], 2'h0);
    op(2, NIBIO_SEL_IN, 4'h0, 2'h0);
    rd(4'h5, 4'h0);
    `CHK("refused", {lat[0], ~lat[1], ~lat[2]}, {oo, aoe, boe})
    $display("test refusals done");
    RST_N = 0;
    eoe = 8'h00;
    repeat (2) @(posedge CLK_SYS);
    `CHK("oe_rst2", 4'h0, ooe | aoe | boe)
    `CHK("pu_rst2", 12'hF0F, {apu, bpu, x_bpu})
    #1 RST_N = 1;
    rd(NIBIO_SEL_BIDIR_A, 4'hF);
    $display("test second reset done");
    test_done();
  end
endmodule
